// *** alarm_pkg.sv ***
// Shared constants and types for the two-channel alarm relay block.
// Assumes a 125 MHz system clock and 32-bit APB register access.
package alarm_pkg;

	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned SECOND_S = 1;
	localparam int unsigned TICK_CYCLES = CLK_HZ * SECOND_S;

	localparam int unsigned NUM_CH = 2;
	localparam int unsigned VAL_W = 32;
	localparam int unsigned DLY_W = 10;

	// Byte offsets; channel n sits at n * CH_STRIDE.
	localparam logic [7:0] CH_STRIDE = 8'h20;
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_LOW = 5'h04;
	localparam logic [4:0] OFS_HIGH = 5'h08;
	localparam logic [4:0] OFS_DLY_ON = 5'h0c;
	localparam logic [4:0] OFS_DLY_OFF = 5'h10;
	localparam logic [4:0] OFS_LOCK = 5'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h40;

	// Control word fields.
	localparam int unsigned CTRL_SRC_LSB = 0;
	localparam int unsigned CTRL_KIND_LSB = 4;
	localparam int unsigned CTRL_LATCH_BIT = 8;

	// Status word fields.
	localparam int unsigned ST_RELAY_LSB = 0;
	localparam int unsigned ST_LATCHED_LSB = 4;
	localparam int unsigned ST_LED_LSB = 8;

	localparam logic [VAL_W-1:0] LIMIT_MAX = 32'h0001869f;
	localparam logic [VAL_W-1:0] LIMIT_MIN = 32'hfffe7961;
	localparam logic [DLY_W-1:0] DELAY_MAX = 10'h384;

	typedef enum logic [1:0] {
		SRC_MEAS = 2'h0,
		SRC_TIME = 2'h1,
		SRC_SECOND = 2'h2
	} alarm_source_select_t;

	typedef enum logic [2:0] {
		KIND_N_ON = 3'h0,
		KIND_N_OFF = 3'h1,
		KIND_ON = 3'h2,
		KIND_OFF = 3'h3,
		KIND_H_ON = 3'h4,
		KIND_H_OFF = 3'h5
	} alarm_behaviour_type_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_WAIT_ON = 4'b0010,
		ST_ACTIVE = 4'b0100,
		ST_WAIT_OFF = 4'b1000
	} chan_state_t;

	typedef struct packed {
		alarm_source_select_t src;
		alarm_behaviour_type_t kind;
		logic latchEn;
		logic [VAL_W-1:0] lowLimit;
		logic [VAL_W-1:0] highLimit;
		logic [DLY_W-1:0] activateDelay;
		logic [DLY_W-1:0] deactivateDelay;
		logic [DLY_W-1:0] reactivateLockout;
	} chan_cfg_t;

	localparam chan_cfg_t CFG_RESET = '{
		src: SRC_MEAS,
		kind: KIND_N_ON,
		latchEn: 1'b0,
		lowLimit: 32'h00000000,
		highLimit: 32'h00000000,
		activateDelay: 10'h000,
		deactivateDelay: 10'h000,
		reactivateLockout: 10'h000
	};

endpackage

// *** alarm_sec_timer.sv ***
// Down-counter of whole seconds used for alarm delays and lockout.
// Assumes a one-cycle seconds tick from the same clock domain.
`timescale 1ns/1ps
module alarm_sec_timer #(
	parameter int unsigned W = 10
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [W-1:0] loadVal,
	input wire logic tick,
	output logic running
);
	logic [W-1:0] count_r;

	initial begin
		if (W < 1) begin
			$error("alarm_sec_timer: W must be at least 1");
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			count_r <= '0;
		end else if (load) begin
			count_r <= loadVal;
		end else if (tick && count_r != '0) begin
			count_r <= count_r - 1'b1;
		end
	end

	assign running = (count_r != '0);
endmodule

// *** dual_alarm_relay_control.sv ***
// Two alarm channels: window compare, timed relay switching, LED indication, APB registers.
// Assumes input quantities synchronous to clk_sys and an APB master on the same clock.
// Operation
// - Each channel picks measured value, time of day or second value as input.
// - Normal types switch output on or off as the quantity leaves the window.
// - Manual forced-on holds output active until the type setting changes.
// - Manual forced-off holds output inactive until the type setting changes.
// - Lower threshold per channel, signed, from -99999 to 99999.
// - Upper threshold per channel, signed, from -99999 to 99999.
// - After the switch-on condition, wait 0 to 900 seconds before activating.
// - After the switch-off condition, wait 0 to 900 seconds before deactivating.
// - After switching on, block another switch-on for a 0 to 900 second lockout.
// - With latching disabled there is no persistent switch-on indication.
// - With latching enabled the channel LED blinks while the relay is off, once the alarm has switched on.
`timescale 1ns/1ps
module dual_alarm_relay_control #(
	parameter int unsigned TICK_CYCLES = alarm_pkg::TICK_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [alarm_pkg::VAL_W-1:0] measValue,
	input wire logic [alarm_pkg::VAL_W-1:0] timeOfDay,
	input wire logic [alarm_pkg::VAL_W-1:0] secondValue,
	output logic [alarm_pkg::NUM_CH-1:0] relayOut,
	output logic firstAlarmLed,
	output logic secondAlarmLed
);
	localparam int unsigned NCH = alarm_pkg::NUM_CH;

	initial begin
		if (TICK_CYCLES < 2) begin
			$error("dual_alarm_relay_control: TICK_CYCLES must be at least 2");
		end
	end

	alarm_pkg::chan_cfg_t cfg_r [NCH];
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic [NCH-1:0] relay_r;
	logic [NCH-1:0] latched_r;
	logic [NCH-1:0] led_r;
	logic [NCH-1:0] relayNxt;
	logic [NCH-1:0] ledNxt;
	logic [31:0] tickCnt_r;
	logic tick_r;
	logic blink_r;
	logic setupPhase;
	logic wrAccess;
	logic chSel;
	logic [4:0] ofs;
	logic chanHit;
	logic statusHit;
	logic [31:0] rdData;

	// Seconds tick shared by every delay and lockout timer.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tickCnt_r <= 32'h00000000;
			tick_r <= 1'b0;
		end else if (tickCnt_r == TICK_CYCLES - 1) begin
			tickCnt_r <= 32'h00000000;
			tick_r <= 1'b1;
		end else begin
			tickCnt_r <= tickCnt_r + 32'h00000001;
			tick_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			blink_r <= 1'b0;
		end else if (tick_r) begin
			blink_r <= ~blink_r;
		end
	end

	// APB decode. The answer is prepared at the setup edge, so access takes one cycle.
	assign setupPhase = psel & ~penable;
	assign wrAccess = psel & penable & pready_r & pwrite;
	assign chSel = paddr[5];
	assign ofs = paddr[4:0];
	assign chanHit = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0) && (ofs <= alarm_pkg::OFS_LOCK);
	assign statusHit = (paddr == alarm_pkg::ADDR_STATUS);

	function automatic logic [31:0] clampLimit(input logic [31:0] v);
		if ($signed(v) > $signed(alarm_pkg::LIMIT_MAX)) begin
			return alarm_pkg::LIMIT_MAX;
		end else if ($signed(v) < $signed(alarm_pkg::LIMIT_MIN)) begin
			return alarm_pkg::LIMIT_MIN;
		end
		return v;
	endfunction

	function automatic logic [alarm_pkg::DLY_W-1:0] clampDelay(input logic [31:0] v);
		if (v > {22'h000000, alarm_pkg::DELAY_MAX}) begin
			return alarm_pkg::DELAY_MAX;
		end
		return v[alarm_pkg::DLY_W-1:0];
	endfunction

	always_comb begin
		rdData = 32'h00000000;
		if (statusHit) begin
			rdData[alarm_pkg::ST_RELAY_LSB +: NCH] = relay_r;
			rdData[alarm_pkg::ST_LATCHED_LSB +: NCH] = latched_r;
			rdData[alarm_pkg::ST_LED_LSB +: NCH] = led_r;
		end else if (chanHit) begin
			unique case (ofs)
				alarm_pkg::OFS_CTRL: begin
					rdData[alarm_pkg::CTRL_SRC_LSB +: 2] = cfg_r[chSel].src;
					rdData[alarm_pkg::CTRL_KIND_LSB +: 3] = cfg_r[chSel].kind;
					rdData[alarm_pkg::CTRL_LATCH_BIT] = cfg_r[chSel].latchEn;
				end
				alarm_pkg::OFS_LOW: rdData = cfg_r[chSel].lowLimit;
				alarm_pkg::OFS_HIGH: rdData = cfg_r[chSel].highLimit;
				alarm_pkg::OFS_DLY_ON: rdData[9:0] = cfg_r[chSel].activateDelay;
				alarm_pkg::OFS_DLY_OFF: rdData[9:0] = cfg_r[chSel].deactivateDelay;
				alarm_pkg::OFS_LOCK: rdData[9:0] = cfg_r[chSel].reactivateLockout;
				default: rdData = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pready_r <= 1'b0;
			prdata_r <= 32'h00000000;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= setupPhase;
			if (setupPhase) begin
				prdata_r <= pwrite ? 32'h00000000 : rdData;
				pslverr_r <= ~(chanHit | statusHit);
			end else begin
				prdata_r <= 32'h00000000;
				pslverr_r <= 1'b0;
			end
		end
	end

	// Configuration writes; out-of-range limits and delays are clamped to the legal span.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NCH; i++) begin
				cfg_r[i] <= alarm_pkg::CFG_RESET;
			end
		end else if (wrAccess && chanHit) begin
			unique case (ofs)
				alarm_pkg::OFS_CTRL: begin
					cfg_r[chSel].src <= (pwdata[1:0] == 2'h3) ? alarm_pkg::SRC_MEAS :
						alarm_pkg::alarm_source_select_t'(pwdata[1:0]);
					if (pwdata[6:4] <= 3'h5) begin
						cfg_r[chSel].kind <= alarm_pkg::alarm_behaviour_type_t'(pwdata[6:4]);
					end
					cfg_r[chSel].latchEn <= pwdata[alarm_pkg::CTRL_LATCH_BIT];
				end
				alarm_pkg::OFS_LOW: cfg_r[chSel].lowLimit <= clampLimit(pwdata);
				alarm_pkg::OFS_HIGH: cfg_r[chSel].highLimit <= clampLimit(pwdata);
				alarm_pkg::OFS_DLY_ON: cfg_r[chSel].activateDelay <= clampDelay(pwdata);
				alarm_pkg::OFS_DLY_OFF: cfg_r[chSel].deactivateDelay <= clampDelay(pwdata);
				alarm_pkg::OFS_LOCK: cfg_r[chSel].reactivateLockout <= clampDelay(pwdata);
				default: cfg_r[chSel] <= cfg_r[chSel];
			endcase
		end
	end

	for (genvar gi = 0; gi < NCH; gi++) begin : gChan
		alarm_pkg::chan_state_t state_r;
		alarm_pkg::chan_state_t state_nxt;
		alarm_pkg::alarm_behaviour_type_t kindPrev_r;
		logic [alarm_pkg::VAL_W-1:0] qVal;
		logic onCond;
		logic offCond;
		logic onLoad;
		logic offLoad;
		logic onRun;
		logic offRun;
		logic lockRun;
		logic relayCh;

		always_comb begin
			unique case (cfg_r[gi].src)
				alarm_pkg::SRC_TIME: qVal = timeOfDay;
				alarm_pkg::SRC_SECOND: qVal = secondValue;
				default: qVal = measValue;
			endcase
		end

		// Window crossing with hysteresis between the two limits.
		always_comb begin
			if (cfg_r[gi].kind == alarm_pkg::KIND_N_OFF) begin
				onCond = $signed(qVal) < $signed(cfg_r[gi].lowLimit);
				offCond = $signed(qVal) > $signed(cfg_r[gi].highLimit);
			end else begin
				onCond = $signed(qVal) > $signed(cfg_r[gi].highLimit);
				offCond = $signed(qVal) < $signed(cfg_r[gi].lowLimit);
			end
		end

		always_comb begin
			state_nxt = state_r;
			onLoad = 1'b0;
			offLoad = 1'b0;
			unique case (state_r)
				alarm_pkg::ST_IDLE: begin
					if (onCond) begin
						onLoad = 1'b1;
						state_nxt = alarm_pkg::ST_WAIT_ON;
					end
				end
				alarm_pkg::ST_WAIT_ON: begin
					if (!onCond) begin
						state_nxt = alarm_pkg::ST_IDLE;
					end else if (!onRun && !lockRun) begin
						state_nxt = alarm_pkg::ST_ACTIVE;
					end
				end
				alarm_pkg::ST_ACTIVE: begin
					if (offCond) begin
						offLoad = 1'b1;
						state_nxt = alarm_pkg::ST_WAIT_OFF;
					end
				end
				alarm_pkg::ST_WAIT_OFF: begin
					if (!offCond) begin
						state_nxt = alarm_pkg::ST_ACTIVE;
					end else if (!offRun) begin
						state_nxt = alarm_pkg::ST_IDLE;
					end
				end
				default: state_nxt = alarm_pkg::ST_IDLE;
			endcase
			// A change of type restarts the normal sequence from the inactive state.
			if (cfg_r[gi].kind != kindPrev_r) begin
				state_nxt = alarm_pkg::ST_IDLE;
			end
		end

		always_comb begin
			unique case (cfg_r[gi].kind)
				alarm_pkg::KIND_ON: relayCh = 1'b1;
				alarm_pkg::KIND_OFF: relayCh = 1'b0;
				alarm_pkg::KIND_H_ON: relayCh = 1'b1;
				alarm_pkg::KIND_H_OFF: relayCh = 1'b0;
				default: relayCh = (state_nxt == alarm_pkg::ST_ACTIVE) ||
					(state_nxt == alarm_pkg::ST_WAIT_OFF);
			endcase
		end

		always_ff @(posedge clk_sys or negedge rst_n) begin
			if (!rst_n) begin
				state_r <= alarm_pkg::ST_IDLE;
				kindPrev_r <= alarm_pkg::KIND_N_ON;
			end else begin
				state_r <= state_nxt;
				kindPrev_r <= cfg_r[gi].kind;
			end
		end

		alarm_sec_timer #(.W(alarm_pkg::DLY_W)) uOnTimer (
			.clk_sys(clk_sys),
			.rst_n(rst_n),
			.load(onLoad),
			.loadVal(cfg_r[gi].activateDelay),
			.tick(tick_r),
			.running(onRun)
		);

		alarm_sec_timer #(.W(alarm_pkg::DLY_W)) uOffTimer (
			.clk_sys(clk_sys),
			.rst_n(rst_n),
			.load(offLoad),
			.loadVal(cfg_r[gi].deactivateDelay),
			.tick(tick_r),
			.running(offRun)
		);

		alarm_sec_timer #(.W(alarm_pkg::DLY_W)) uLockTimer (
			.clk_sys(clk_sys),
			.rst_n(rst_n),
			.load(relayNxt[gi] & ~relay_r[gi]),
			.loadVal(cfg_r[gi].reactivateLockout),
			.tick(tick_r),
			.running(lockRun)
		);

		assign relayNxt[gi] = relayCh;
		// The LED follows the relay; a latched switch-on adds blinking while the relay is off.
		assign ledNxt[gi] = relayCh | (cfg_r[gi].latchEn & latched_r[gi] & blink_r);
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			relay_r <= '0;
			led_r <= '0;
		end else begin
			relay_r <= relayNxt;
			led_r <= ledNxt;
		end
	end

	// Latched switch-on record; a new switch-on wins over a clear in the same cycle.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			latched_r <= '0;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (!cfg_r[i].latchEn) begin
					latched_r[i] <= 1'b0;
				end else if (relayNxt[i] && !relay_r[i]) begin
					latched_r[i] <= 1'b1;
				end else if (wrAccess && statusHit && pwdata[alarm_pkg::ST_LATCHED_LSB + i]) begin
					latched_r[i] <= 1'b0;
				end
			end
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign relayOut = relay_r;
	assign firstAlarmLed = led_r[0];
	assign secondAlarmLed = led_r[1];
endmodule

// *** alarm_relay_properties.sv ***
// Concurrent checks on the ports of the two-channel alarm relay block.
// Assumes one clock domain and an APB master that keeps the protocol.
`timescale 1ns/1ps
module alarm_relay_checker (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [alarm_pkg::VAL_W-1:0] measValue,
	input wire logic [alarm_pkg::VAL_W-1:0] timeOfDay,
	input wire logic [alarm_pkg::VAL_W-1:0] secondValue,
	input wire logic [alarm_pkg::NUM_CH-1:0] relayOut,
	input wire logic firstAlarmLed,
	input wire logic secondAlarmLed
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	property p_ready_after_setup;
		psel && !penable |=> pready;
	endproperty
	a_ready_after_setup: assert property (p_ready_after_setup) else $error("pready missing");
	property p_ready_single;
		pready |=> !pready;
	endproperty
	a_ready_single: assert property (p_ready_single) else $error("pready too long");
	property p_err_with_ready;
		pslverr |-> pready;
	endproperty
	a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr alone");
	property p_rdata_quiet;
		!pready |-> prdata == 32'h0;
	endproperty
	a_rdata_quiet: assert property (p_rdata_quiet) else $error("prdata not zero");
	property p_unmapped_err;
		psel && !penable && paddr >= 8'h44 |=> pslverr;
	endproperty
	a_unmapped_err: assert property (p_unmapped_err) else $error("no pslverr");
	property p_reset_quiet;
		$rose(rst_n) |-> relayOut == 2'b00 && !firstAlarmLed && !secondAlarmLed;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs after reset");
	property p_led1_relay;
		relayOut[0] |-> firstAlarmLed;
	endproperty
	a_led1_relay: assert property (p_led1_relay) else $error("first led off");
	property p_led2_relay;
		relayOut[1] |-> secondAlarmLed;
	endproperty
	a_led2_relay: assert property (p_led2_relay) else $error("second led off");

	c_relay_on: cover property ($rose(relayOut[0]));
	c_err: cover property (pslverr);
	c_blink: cover property (firstAlarmLed && !relayOut[0]);
endmodule

bind dual_alarm_relay_control alarm_relay_checker u_alarm_relay_checker (.clk_sys, .rst_n,
	.paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .measValue,
	.timeOfDay, .secondValue, .relayOut, .firstAlarmLed, .secondAlarmLed);

// *** alarm_contacts_model.sv ***
// Relay contact model: counts closures of the first channel's contact.
// Assumes relay drive is synchronous to clk_sys.
`timescale 1ns/1ps
module alarm_contacts_model (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [1:0] relayOut,
	output logic [7:0] closures
);
	logic prev_r;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prev_r <= 1'b0;
			closures <= 8'h00;
		end else begin
			prev_r <= relayOut[0];
			if (relayOut[0] && !prev_r) begin
				closures <= closures + 8'h01;
			end
		end
	end
endmodule

// *** tb_top.sv ***
// Self-checking bench for the alarm relay block over APB.
// Assumes a shortened seconds tick of ten clock cycles.
`timescale 1ns/1ps
module tb_top;
	logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, er, seen;
	logic [7:0] paddr, closures;
	logic [31:0] pwdata, prdata, rd, measValue, timeOfDay, secondValue;
	logic [1:0] relayOut;
	logic firstAlarmLed, secondAlarmLed;
	logic [2:0] kinds [4];
	int errors, checks_done;

	dual_alarm_relay_control #(.TICK_CYCLES(10)) u_dual_alarm_relay_control (.clk_sys, .rst_n,
		.paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .measValue,
		.timeOfDay, .secondValue, .relayOut, .firstAlarmLed, .secondAlarmLed);
	alarm_contacts_model u_alarm_contacts_model (.clk_sys, .rst_n, .relayOut, .closures);

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task print_verdict;
		if (errors == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		@(posedge clk_sys);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge clk_sys);
			n++;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			errors++;
			print_verdict;
		end
	endtask

	task wait_relay(input int ch, input logic v, input int lim);
		int n;
		n = 0;
		while (relayOut[ch] !== v && n < lim) begin
			@(posedge clk_sys);
			n++;
		end
		chk("relay", {31'h0, v}, {31'h0, relayOut[ch]});
		if (n >= lim) print_verdict;
	endtask

	task watch_led(input int lim);
		seen = 1'b0;
		repeat (lim) begin
			@(posedge clk_sys);
			if (firstAlarmLed === 1'b1 && relayOut[0] === 1'b0) seen = 1'b1;
		end
	endtask

	initial begin
		rst_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{measValue, timeOfDay, secondValue} = '0;
		errors = 0;
		checks_done = 0;
		kinds = '{3'h2, 3'h3, 3'h4, 3'h5};
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		apb(1'b0, 8'h40, 32'h0);
		chk("status", 32'h0, rd);
		apb(1'b0, 8'h80, 32'h0);
		chk("unmapped", 32'h1, {31'h0, er});
		apb(1'b0, 8'h06, 32'h0);
		chk("unaligned", 32'h1, {31'h0, er});
		apb(1'b1, 8'h04, 32'hfff00000);
		apb(1'b0, 8'h04, 32'h0);
		chk("low clamp", alarm_pkg::LIMIT_MIN, rd);
		apb(1'b1, 8'h08, 32'h00100000);
		apb(1'b0, 8'h08, 32'h0);
		chk("high clamp", alarm_pkg::LIMIT_MAX, rd);
		apb(1'b1, 8'h04, 32'd10);
		apb(1'b1, 8'h08, 32'd20);
		apb(1'b1, 8'h14, 32'd5);
		measValue <= 32'd30;
		wait_relay(0, 1'b1, 6);
		measValue <= 32'd5;
		wait_relay(0, 1'b0, 6);
		measValue <= 32'd30;
		repeat (20) @(posedge clk_sys);
		chk("lockout", 32'h0, {31'h0, relayOut[0]});
		wait_relay(0, 1'b1, 70);
		@(posedge clk_sys);
		chk("closures", 32'd2, {24'h0, closures});
		timeOfDay <= 32'd15;
		apb(1'b1, 8'h24, 32'd10);
		apb(1'b1, 8'h28, 32'd20);
		apb(1'b1, 8'h2c, 32'd3);
		apb(1'b1, 8'h20, 32'h11);
		timeOfDay <= 32'd5;
		repeat (15) @(posedge clk_sys);
		chk("on delay", 32'h0, {31'h0, relayOut[1]});
		wait_relay(1, 1'b1, 30);
		apb(1'b1, 8'h30, 32'd2);
		timeOfDay <= 32'd25;
		repeat (5) @(posedge clk_sys);
		chk("off delay", 32'h1, {31'h0, relayOut[1]});
		wait_relay(1, 1'b0, 30);
		// Second channel now watches the second value; time of day alone must not switch it.
		apb(1'b1, 8'h20, 32'h2);
		repeat (35) @(posedge clk_sys);
		chk("source second", 32'h0, {31'h0, relayOut[1]});
		secondValue <= 32'd30;
		wait_relay(1, 1'b1, 40);
		apb(1'b1, 8'h14, 32'd0);
		measValue <= 32'd5;
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 8'h00, {25'h0, kinds[i], 4'h0});
			repeat (2) @(posedge clk_sys);
			chk("fixed kind", {31'h0, ~i[0]}, {31'h0, relayOut[0]});
		end
		apb(1'b1, 8'h00, 32'h100);
		measValue <= 32'd30;
		wait_relay(0, 1'b1, 6);
		measValue <= 32'd5;
		wait_relay(0, 1'b0, 6);
		apb(1'b0, 8'h40, 32'h0);
		chk("latched", 32'h1, (rd >> 4) & 32'h1);
		watch_led(30);
		chk("blink", 32'h1, {31'h0, seen});
		apb(1'b1, 8'h00, 32'h0);
		// The LED register still holds one blink sample taken before the write landed.
		repeat (2) @(posedge clk_sys);
		watch_led(30);
		chk("no blink", 32'h0, {31'h0, seen});
		apb(1'b1, 8'h00, 32'h100);
		measValue <= 32'd30;
		wait_relay(0, 1'b1, 6);
		measValue <= 32'd5;
		wait_relay(0, 1'b0, 6);
		apb(1'b1, 8'h40, 32'h10);
		apb(1'b0, 8'h40, 32'h0);
		chk("latch clear", 32'h0, (rd >> 4) & 32'h1);
		print_verdict;
	end
endmodule
